// ### logic/lft_pkg.sv
// package for the flash target front end: codes, field layouts, carriers
package lft_pkg;
	localparam logic [3:0] LFT_START_READ  = 4'hD;
	localparam logic [3:0] LFT_START_WRITE = 4'hE;
	localparam logic [3:0] LFT_TAR_NIBBLE  = 4'hF;
	localparam logic [3:0] LFT_SYNC_READY  = 4'h0;
	localparam int         LFT_ADDR_NIBBLES = 7;
	localparam int         LFT_ADDR_BITS    = 28;
	localparam int         LFT_DATA_BITS    = 8;
	localparam logic [3:0] LFT_SIZE_1   = 4'h0;
	localparam logic [3:0] LFT_SIZE_2   = 4'h1;
	localparam logic [3:0] LFT_SIZE_4   = 4'h2;
	localparam logic [3:0] LFT_SIZE_16  = 4'h4;
	localparam logic [3:0] LFT_SIZE_128 = 4'h7;
	localparam logic [27:0] LFT_BOOT_BASE = 28'h01FC000;
	localparam logic [27:0] LFT_MEM_MASK  = 28'h01FFFFF;
	localparam logic [4:0]  LFT_GPI_RESET = 5'h00;
	localparam int          LFT_FIFO_DEPTH = 8;

	typedef enum logic [3:0] {
		LFT_IDLE   = 4'h0,
		LFT_CSEL   = 4'h1,
		LFT_ADDR   = 4'h3,
		LFT_SIZE   = 4'h2,
		LFT_WDATA  = 4'h6,
		LFT_TAR0   = 4'h7,
		LFT_TAR1   = 4'h5,
		LFT_SYNC   = 4'h4,
		LFT_RDATA  = 4'hC,
		LFT_ETAR0  = 4'hD,
		LFT_ETAR1  = 4'hF,
		LFT_SKIP   = 4'hE
	} lft_state_t;

	typedef struct packed {
		logic        is_write;
		logic [27:0] addr;
		logic [3:0]  size;
		logic [7:0]  data;
	} lft_req_t;
endpackage

// ### logic/lft_top.sv
// flash target bus front end: cycle decode, chip select, protection, mode pins, request fifo
// Functional notes
// - fields travel on four-bit nibble bus
// - frame strobe starts or aborts cycle
// - start code is nibble when frame rises
// - only read 1101 and write 1110 accepted
// - read sizes 1,2,4,16,128; write 1,2,4
// - standby when frame high and idle
// - either reset input low resets device
// - reset during read releases nibble bus
// - reset aborts running program or erase
// - general inputs readable, board keeps stable
// - top-lock low refuses boot block writes
// - boot protect is pin OR lock bit
// - clearing boot bit under pin lock ineffective
// - other blocks: protect pin OR lock bits
// - both pins govern only own region
// - supervoltage selects auto-increment mode
// - auto-increment loads on clock while strobe low; here the strobe only picks the ready flag source
// - ready flag: buffer free or op complete
// - operations begin only via write cycles
// - respond only when select matches straps
// - address is seven nibbles, msn first
`timescale 1ns/1ps

// generic first-word-fall-through fifo with valid/ready on both sides
module lft_fifo #(
	parameter int WIDTH = 41,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic             push, pop;

	// full when pointers differ only in the wrap bit
	assign in_ready  = !((wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]));
	assign out_valid = (wptr_reg != rptr_reg);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rptr_reg[AW-1:0]];

	always_comb begin
		wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
		rptr_next = pop  ? rptr_reg + 1'b1 : rptr_reg;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
		end
	end

	// storage carries no reset; only pointers define content
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wptr_reg[AW-1:0]] <= in_data;
		end
	end
endmodule // lft_fifo

module lft_top
	import lft_pkg::*;
#(
	parameter int FIFO_DEPTH = LFT_FIFO_DEPTH
) (
	input  wire logic             clk_sys,           // host bus clock
	input  wire logic             rstn,
	input  wire logic             bus_reset_n,
	input  wire logic             init_reset_n,
	input  wire logic             frame_n,
	input  wire logic [3:0]       nibble_in,
	output logic      [3:0]       nibble_out,
	output logic                  nibble_oe,
	input  wire logic [3:0]       chip_strap_select,
	input  wire logic [4:0]       general_inputs,
	output logic      [4:0]       general_inputs_value,
	input  wire logic             top_region_lock_n,
	input  wire logic             protect_or_mode_pin,
	input  wire logic             supervoltage_seen,
	input  wire logic             boot_lock_bit,
	input  wire logic             block_lock_bit,
	input  wire logic             load_strobe_n,
	input  wire logic             op_busy,
	output logic                  auto_increment_mode,
	output logic                  ready_flag_n_out,
	output logic                  ready_flag_n_oe,
	output logic                  standby,
	output logic                  op_abort,
	output logic                  write_refused,
	input  wire logic [7:0]       read_data,
	output logic                  req_valid,
	input  wire logic             req_ready,
	output lft_req_t              req_data
);
	initial begin
		if (FIFO_DEPTH < 2) $error("fifo depth too small");
	end

	// two-stage synchronisers for the bus, reset, general-input, protection and mode pins; straps, lock bits, op_busy and read_data are used directly
	localparam int SW = 16;
	logic [SW-1:0] sync1_reg, sync2_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= {SW{1'b1}};
			sync2_reg <= {SW{1'b1}};
		end else begin
			sync1_reg <= {bus_reset_n, init_reset_n, frame_n, nibble_in, general_inputs,
				top_region_lock_n, protect_or_mode_pin, supervoltage_seen, load_strobe_n};
			sync2_reg <= sync1_reg;
		end
	end
	logic       s_rst_n, s_frame_n, s_tbl_n, s_wp_n, s_hv, s_ld_n;
	logic [3:0] s_nib;
	logic [4:0] s_gpi;
	assign {s_rst_n, s_frame_n, s_nib, s_gpi, s_tbl_n, s_wp_n, s_hv, s_ld_n} =
		{sync2_reg[15] & sync2_reg[14], sync2_reg[13:0]};

	// cycle state
	lft_state_t  st_reg, st_next;
	logic        wr_reg, wr_next;
	logic [27:0] addr_reg, addr_next;
	logic [3:0]  size_reg, size_next;
	logic [7:0]  cnt_reg, cnt_next;
	logic [7:0]  wbyte_reg, wbyte_next;
	logic [3:0]  nout_reg, nout_next;
	logic        oe_reg, oe_next;
	logic        push_reg, push_next;
	logic        mode_reg, mode_next;
	logic [4:0]  gpi_reg, gpi_next;
	logic        fifo_in_ready;
	logic        boot_hit, protect;

	// boot region is the top 16 KByte
	assign boot_hit = ((addr_reg & LFT_MEM_MASK) >= LFT_BOOT_BASE);
	// each pin guards only its own region, pin OR lock bit
	assign protect = boot_hit ? (!s_tbl_n || boot_lock_bit)
	                          : (!s_wp_n || block_lock_bit);

	// cycle decoder; frame low always restarts from start-code capture
	always_comb begin
		st_next    = st_reg;
		wr_next    = wr_reg;
		addr_next  = addr_reg;
		size_next  = size_reg;
		cnt_next   = cnt_reg;
		wbyte_next = wbyte_reg;
		nout_next  = LFT_TAR_NIBBLE;
		oe_next    = 1'b0;
		push_next  = 1'b0;
		if (!s_frame_n) begin
			st_next = LFT_IDLE;
			if (s_nib == LFT_START_READ || s_nib == LFT_START_WRITE) begin
				st_next = LFT_CSEL;
				wr_next = (s_nib == LFT_START_WRITE);
			end
		end else begin
			unique case (st_reg)
				LFT_IDLE: st_next = LFT_IDLE;
				LFT_CSEL: begin
					cnt_next = 8'h00;
					st_next  = (s_nib == chip_strap_select) ? LFT_ADDR : LFT_SKIP;
				end
				LFT_ADDR: begin
					addr_next = {addr_reg[23:0], s_nib};
					cnt_next  = cnt_reg + 8'h01;
					if (cnt_reg == 8'(LFT_ADDR_NIBBLES - 1)) st_next = LFT_SIZE;
				end
				LFT_SIZE: begin
					size_next = s_nib;
					cnt_next  = 8'h00;
					if (wr_reg && (s_nib == LFT_SIZE_1 || s_nib == LFT_SIZE_2 || s_nib == LFT_SIZE_4)) begin
						st_next = LFT_WDATA;
					end else if (!wr_reg && (s_nib == LFT_SIZE_1 || s_nib == LFT_SIZE_2 ||
					             s_nib == LFT_SIZE_4 || s_nib == LFT_SIZE_16 || s_nib == LFT_SIZE_128)) begin
						st_next = LFT_TAR0;
					end else begin
						st_next = LFT_SKIP;
					end
				end
				LFT_WDATA: begin
					// low nibble first; a byte is queued after its high nibble
					wbyte_next = {s_nib, wbyte_reg[7:4]};
					cnt_next   = cnt_reg + 8'h01;
					push_next  = cnt_reg[0];
					if (cnt_reg == 8'((2 << size_reg) - 1)) st_next = LFT_TAR0;
				end
				LFT_TAR0: st_next = LFT_TAR1;
				LFT_TAR1: begin
					st_next   = LFT_SYNC;
					oe_next   = 1'b1;
					nout_next = LFT_SYNC_READY;
				end
				LFT_SYNC: begin
					cnt_next = 8'h00;
					oe_next  = 1'b1;
					if (wr_reg) begin
						st_next   = LFT_ETAR0;
						nout_next = LFT_TAR_NIBBLE;
					end else begin
						st_next   = LFT_RDATA;
						nout_next = read_data[3:0];
					end
				end
				LFT_RDATA: begin
					cnt_next  = cnt_reg + 8'h01;
					oe_next   = 1'b1;
					nout_next = cnt_reg[0] ? read_data[3:0] : read_data[7:4];
					if (cnt_reg == 8'((2 << size_reg) - 1)) begin
						st_next   = LFT_ETAR0;
						nout_next = LFT_TAR_NIBBLE;
					end
				end
				LFT_ETAR0: st_next = LFT_ETAR1;
				LFT_ETAR1: st_next = LFT_IDLE;
				LFT_SKIP:  st_next = LFT_SKIP;
				default:   st_next = LFT_IDLE;
			endcase
		end
		// write sync phase drives only after host turnaround
		if (st_reg == LFT_TAR1 && wr_reg) begin
			oe_next = 1'b1;
		end
		if (!fifo_in_ready) begin
			push_next = 1'b0;
		end
	end

	// mode and general inputs sampled every clock
	always_comb begin
		mode_next = s_hv;
		gpi_next  = s_gpi;
	end

	// pin resets act synchronously; async rstn covers power-up
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_reg    <= LFT_IDLE;
			wr_reg    <= 1'b0;
			addr_reg  <= 28'h0000000;
			size_reg  <= 4'h0;
			cnt_reg   <= 8'h00;
			wbyte_reg <= 8'h00;
			nout_reg  <= LFT_TAR_NIBBLE;
			oe_reg    <= 1'b0;
			push_reg  <= 1'b0;
			mode_reg  <= 1'b0;
			gpi_reg   <= LFT_GPI_RESET;
		end else if (!s_rst_n) begin
			st_reg   <= LFT_IDLE;
			oe_reg   <= 1'b0;
			push_reg <= 1'b0;
			nout_reg <= LFT_TAR_NIBBLE;
			mode_reg <= mode_next;
			gpi_reg  <= gpi_next;
		end else begin
			st_reg    <= st_next;
			wr_reg    <= wr_next;
			addr_reg  <= addr_next;
			size_reg  <= size_next;
			cnt_reg   <= cnt_next;
			wbyte_reg <= wbyte_next;
			nout_reg  <= nout_next;
			oe_reg    <= oe_next;
			push_reg  <= push_next && !protect && !mode_reg;
			mode_reg  <= mode_next;
			gpi_reg   <= gpi_next;
		end
	end

	lft_fifo #(
		.WIDTH ($bits(lft_req_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (push_reg),
		.in_ready  (fifo_in_ready),
		.in_data   ({1'b1, addr_reg, size_reg, wbyte_reg}),
		.out_valid (req_valid),
		.out_ready (req_ready),
		.out_data  (req_data)
	);

	assign nibble_out           = nout_reg;
	assign nibble_oe            = oe_reg;
	assign general_inputs_value = gpi_reg;
	assign auto_increment_mode  = mode_reg;
	assign standby              = s_frame_n && (st_reg == LFT_IDLE) && !op_busy;
	assign op_abort             = !s_rst_n && op_busy;
	assign write_refused        = (st_reg == LFT_WDATA) && protect;
	// open drain, auto-increment mode only: pull low while busy; strobe picks buffer or op flag
	assign ready_flag_n_out     = 1'b0;
	assign ready_flag_n_oe      = mode_reg && (s_ld_n ? op_busy : !fifo_in_ready);
endmodule // lft_top

// ### tb/lft_top_sva.sv
// port assertions for the flash target front end
`timescale 1ns/1ps
module lft_top_sva
	import lft_pkg::*;
#(
	parameter int FIFO_DEPTH = LFT_FIFO_DEPTH
) (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       bus_reset_n,
	input wire logic       init_reset_n,
	input wire logic       frame_n,
	input wire logic       nibble_oe,
	input wire logic [4:0] general_inputs,
	input wire logic [4:0] general_inputs_value,
	input wire logic       supervoltage_seen,
	input wire logic       op_busy,
	input wire logic       auto_increment_mode,
	input wire logic       standby,
	input wire logic       op_abort,
	input wire logic       req_valid,
	input wire logic       req_ready,
	input wire lft_req_t   req_data
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// bounds allow for the two-flop pin synchronisers, plus one register where the output is registered
	chk_pin_reset: assert property ((!(bus_reset_n && init_reset_n))[*4] |-> !nibble_oe)
		else $error("nibble bus driven under pin reset");
	chk_frame_abort: assert property ((!frame_n)[*5] |-> !nibble_oe)
		else $error("nibble bus driven while frame held low");
	chk_standby_idle: assert property (standby |-> !op_busy && $past(frame_n, 2))
		else $error("standby during an operation");
	chk_abort_busy: assert property (op_abort |-> op_busy && !($past(bus_reset_n, 2) && $past(init_reset_n, 2)))
		else $error("abort with no operation");
	chk_mode_entry: assert property ($rose(supervoltage_seen) |-> ##[1:4] auto_increment_mode)
		else $error("mode not entered");
	chk_gpi_lag: assert property ($changed(general_inputs) |-> ##3 general_inputs_value == $past(general_inputs, 3))
		else $error("general input readback wrong");
	chk_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
		else $error("queued request changed while stalled");
	chk_req_kind: assert property (req_valid |-> req_data.is_write && req_data.size inside {4'h0, 4'h1, 4'h2})
		else $error("queued request of bad kind");

	cover property (req_valid && req_ready);
	cover property (req_valid && !req_ready);
	cover property (op_abort);
endmodule // lft_top_sva

bind lft_top lft_top_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.*);

// ### tb/lft_host_model.sv
// host bus master model: frame strobe and host side of the nibble bus
`timescale 1ns/1ps
module lft_host_model (
	input  wire logic       clk_sys,
	input  wire logic [3:0] nibble_out,
	input  wire logic       nibble_oe,
	output logic            frame_n,
	output logic [3:0]      nibble_in
);
	logic       host_oe = 1'b0;
	logic [3:0] host_val = 4'hF;
	logic [3:0] float_val = 4'h5;

	// no pull-up modelled, so an undriven bus shows a pattern that changes every cycle
	always @(negedge clk_sys) float_val <= ~float_val;
	assign nibble_in = nibble_oe ? nibble_out : (host_oe ? host_val : float_val);

	initial frame_n = 1'b1;

	// one nibble per clock, changed just after the falling edge
	task automatic nib(input logic frm, input logic [3:0] val);
		@(negedge clk_sys);
		frame_n = frm;
		host_val = val;
		host_oe = 1'b1;
	endtask

	// turnaround: let go of the bus, frame stays high
	task automatic rel();
		@(negedge clk_sys);
		frame_n = 1'b1;
		host_oe = 1'b0;
	endtask
endmodule // lft_host_model

// ### tb/lft_top_tb_top.sv
// self-checking bench for the flash target front end
`timescale 1ns/1ps
module lft_top_tb_top;
	import lft_pkg::*;
	logic       clk_sys, rstn, bus_reset_n, init_reset_n, frame_n, nibble_oe, top_region_lock_n;
	logic       protect_or_mode_pin, supervoltage_seen, boot_lock_bit, block_lock_bit, load_strobe_n;
	logic       op_busy, auto_increment_mode, ready_flag_n_out, ready_flag_n_oe, standby, op_abort;
	logic       write_refused, req_valid, req_ready;
	logic [3:0] nibble_in, nibble_out, chip_strap_select;
	logic [4:0] general_inputs, general_inputs_value;
	logic [7:0] read_data, lfsr;
	// rows {top_n, prot_n, boot_bit, blk_bit, boot_addr, accepted}
	logic [5:0] pt[8] = '{6'h33, 6'h12, 6'h11, 6'h20, 6'h23, 6'h3A, 6'h34, 6'h37};
	lft_req_t   req_data;
	lft_req_t   exp_q[$];
	int         fail_count, total_checks, cycles, refused_cnt, refused_base;

	lft_top dut (.*);
	lft_host_model host (.*);

	// host-supplied bus clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [40:0] seen, input logic [40:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction

	// hang guard, the run needs far fewer cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// byte model compared at every queue hand-off; each byte carries its cycle's address and size
	always @(posedge clk_sys) if (rstn && req_valid && req_ready) begin
		if (exp_q.size() == 0)
			chk(1, 0);
		else
			chk(req_data, exp_q.pop_front());
	end

	// counts data-phase cycles held back by protection
	always @(negedge clk_sys) if (write_refused === 1'b1) refused_cnt++;

	task automatic sync_wait(input logic ok);
		logic seen;
		seen = 1'b0;
		repeat (12) begin
			@(negedge clk_sys);
			if (nibble_oe === 1'b1 && nibble_out === LFT_SYNC_READY) begin
				seen = 1'b1;
				break;
			end
		end
		chk(seen, ok);
	endtask

	// full cycle; an earlier start nibble precedes the real one
	task automatic wcyc(input logic [3:0] st, input logic [3:0] sel, input logic [27:0] a,
		input logic [3:0] sz, input logic ok);
		int n;
		logic [7:0] d;
		logic ans;
		n = (st == LFT_START_WRITE) ? (1 << sz) : 0;
		// only read or write codes, own select and legal sizes get an answer; protection does not stop it
		ans = (st == LFT_START_READ || st == LFT_START_WRITE) && sel == chip_strap_select &&
			(sz inside {LFT_SIZE_1, LFT_SIZE_2, LFT_SIZE_4} ||
			(st == LFT_START_READ && sz inside {LFT_SIZE_16, LFT_SIZE_128}));
		repeat (4) @(negedge clk_sys);
		host.nib(0, LFT_START_READ);
		host.nib(0, st);
		host.nib(1, sel);
		for (int i = 6; i >= 0; i--) host.nib(1, a[i*4 +: 4]);
		host.nib(1, sz);
		for (int i = 0; i < n; i++) begin
			d = rnd();
			host.nib(1, d[3:0]);
			host.nib(1, d[7:4]);
			if (ok && exp_q.size() < LFT_FIFO_DEPTH) exp_q.push_back({1'b1, a, sz, d});
		end
		host.nib(1, LFT_TAR_NIBBLE);
		host.rel();
		sync_wait(ans);
	endtask

	initial begin
		rstn = 1'b0;
		{bus_reset_n, init_reset_n, top_region_lock_n, protect_or_mode_pin, load_strobe_n, req_ready} = 6'h3F;
		{supervoltage_seen, boot_lock_bit, block_lock_bit, op_busy} = 4'h0;
		chip_strap_select = 4'h0; // boot device strap
		{general_inputs, read_data, lfsr} = {5'h00, 8'h00, 8'h52};
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (3) @(negedge clk_sys);
		general_inputs = 5'(rnd());
		repeat (5) @(negedge clk_sys);
		chk(general_inputs_value, general_inputs);
		// protection pins and lock bits held steady through each cycle
		foreach (pt[i]) begin
			{top_region_lock_n, protect_or_mode_pin, boot_lock_bit, block_lock_bit} = pt[i][5:2];
			refused_base = refused_cnt;
			wcyc(LFT_START_WRITE, 4'h0, pt[i][1] ? LFT_BOOT_BASE : 28'h0000100, 4'(i % 3), pt[i][0]);
			chk(refused_cnt != refused_base, !pt[i][0]);
		end
		{top_region_lock_n, protect_or_mode_pin, boot_lock_bit, block_lock_bit} = 4'hC;
		wcyc(4'hA, 4'h0, 28'h0000200, LFT_SIZE_1, 0);
		wcyc(LFT_START_WRITE, 4'h3, 28'h0000200, LFT_SIZE_1, 0);
		wcyc(LFT_START_WRITE, 4'h0, 28'h0000200, LFT_SIZE_16, 0);
		$display("test decode done");
		read_data = rnd();
		wcyc(LFT_START_READ, 4'h0, 28'h0000300, LFT_SIZE_1, 1);
		@(negedge clk_sys);
		chk({nibble_oe, nibble_out}, {1'b1, read_data[3:0]});
		@(negedge clk_sys);
		chk({nibble_oe, nibble_out}, {1'b1, read_data[7:4]});
		wcyc(LFT_START_READ, 4'h0, 28'h0000300, LFT_SIZE_128, 1);
		init_reset_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(nibble_oe, 0);
		init_reset_n = 1'b1;
		// frame pulled low in mid-address abandons the write
		host.nib(0, LFT_START_WRITE);
		for (int i = 0; i < 4; i++) host.nib(1, 4'h0);
		repeat (6) host.nib(0, LFT_TAR_NIBBLE);
		host.rel();
		sync_wait(0);
		$display("test read and abort done");
		// consumer stalled: queue fills to its depth, extra bytes dropped
		req_ready = 1'b0;
		repeat (3) wcyc(LFT_START_WRITE, 4'h0, 28'h0000400, LFT_SIZE_4, 1);
		chk(req_valid, 1);
		req_ready = 1'b1;
		repeat (12) @(negedge clk_sys);
		chk(exp_q.size(), 0);
		$display("test queue done");
		op_busy = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk({standby, ready_flag_n_oe, ready_flag_n_out}, 3'h0);
		bus_reset_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(op_abort, 1);
		{bus_reset_n, op_busy} = 2'h2;
		repeat (4) @(negedge clk_sys);
		chk({standby, ready_flag_n_oe}, 2'h2);
		{supervoltage_seen, load_strobe_n} = 2'h2;
		repeat (5) @(negedge clk_sys);
		chk(auto_increment_mode, 1);
		// strobe low shows buffer free; strobe high shows the running operation
		chk({ready_flag_n_oe, ready_flag_n_out}, 2'h0);
		{load_strobe_n, op_busy} = 2'h3;
		repeat (4) @(negedge clk_sys);
		chk({ready_flag_n_oe, ready_flag_n_out}, 2'h2);
		$display("test pins done");
		report_and_stop();
	end
endmodule // lft_top_tb_top
